// ---- dpv_pkg.sv ----
/*
  Package for the drive-profile velocity command interpreter: register
  offsets, drive register masks, reset values, state and command types and
  the carriers that join the block to the drive-side register exchange.
  Assumes the importer works on one clock and treats every register image as 16 bits, the order strobe as one bit.
*/
package dpv_pkg;

  // software register offsets on the plain register port
  localparam logic [7:0] DPV_OFS_CONTROL = 8'h00;
  localparam logic [7:0] DPV_OFS_TARGET_VEL = 8'h04;
  localparam logic [7:0] DPV_OFS_SETPOINT = 8'h08;
  localparam logic [7:0] DPV_OFS_STATUS = 8'h0C;
  localparam logic [7:0] DPV_OFS_STATE = 8'h10;

  // control word bit positions
  localparam int DPV_CW_SWITCH_ON = 0;
  localparam int DPV_CW_ENABLE_VOLT = 1;
  localparam int DPV_CW_QUICK_STOP = 2;
  localparam int DPV_CW_ENABLE_OP = 3;
  localparam int DPV_CW_RFG_ENABLE = 4;
  localparam int DPV_CW_RFG_UNLOCK = 5;
  localparam int DPV_CW_RFG_USE_REF = 6;
  localparam int DPV_CW_HALT_RESET = 7;

  // drive status register (inverter address 0x00FC) masks
  localparam logic [15:0] DPV_DRV_STATUS_ADDR = 16'h00FC;
  localparam logic [15:0] DPV_FC_RUN = 16'h0005;
  localparam logic [15:0] DPV_FC_SPEED = 16'h0002;
  localparam logic [15:0] DPV_FC_TARGET = 16'h0010;
  localparam logic [15:0] DPV_FC_READY = 16'h0020;
  localparam logic [15:0] DPV_FC_WARNING = 16'h0040;
  localparam logic [15:0] DPV_FC_FAULT = 16'h0080;
  // drive status word two masks
  localparam logic [15:0] DPV_ST2_NET_CTRL = 16'h0002;
  localparam logic [15:0] DPV_ST2_REMOTE = 16'h0003;

  // drive command register 0x0001 and quick-stop register 0x0014
  localparam logic [15:0] DPV_RUN_REG_ADDR = 16'h0001;
  localparam logic [15:0] DPV_QS_REG_ADDR = 16'h0014;
  localparam logic [15:0] DPV_RUN_FIELD = 16'h0003;
  localparam logic [15:0] DPV_RUN_STOP = 16'h0000;
  localparam logic [15:0] DPV_RUN_FWD = 16'h0001;
  localparam logic [15:0] DPV_RUN_REV = 16'h0002;
  localparam logic [15:0] DPV_FAULT_RESET = 16'h0008;
  localparam logic [15:0] DPV_QS_SELECT = 16'h0004;
  // option status word two: network reference flag
  localparam logic [15:0] DPV_OPT_NET_REF = 16'h0002;

  localparam logic [15:0] DPV_RESET_WORD = 16'h0000;

  typedef enum logic [2:0] {
    ST_NOT_READY, ST_SWITCH_ON_DISABLED, ST_READY, ST_SWITCHED_ON,
    ST_OP_ENABLED, ST_QUICK_STOP, ST_FAULT_REACTION, ST_FAULT
  } dpv_state_type;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_SHUTDOWN, CMD_SWITCH_ON, CMD_SWITCH_ON_ENABLE,
    CMD_DISABLE_VOLTAGE, CMD_QUICK_STOP, CMD_DISABLE_OP, CMD_ENABLE_OP,
    CMD_FAULT_RESET
  } dpv_cmd_type;

  // drive-side inputs: status register image and status word two
  typedef struct packed {
    logic [15:0] status_fc;
    logic [15:0] status_two;
  } dpv_drive_in_type;

  // drive-side outputs: register images plus order strobe
  typedef struct packed {
    logic [15:0] run_ctrl;
    logic [15:0] qs_ctrl;
    logic [15:0] option_status_word_two;
    logic [15:0] setpoint;
    logic order_strobe;
  } dpv_drive_out_type;

endpackage

// ---- dpv_velocity_sm.sv ----
/*
  Drive-profile velocity command interpreter: decodes control words written
  over the plain register port, issues run, quick-stop and fault-reset orders
  to the drive register images, evaluates the profile state machine from the
  drive status and encodes the status word.
  Assumes drive status inputs come from logic on the same clock, and that
  the register master keeps strobes one cycle long and never both at once.
*/
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module dpv_velocity_sm #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic init_ok,
  input wire dpv_pkg::dpv_drive_in_type drive_in,
  output dpv_pkg::dpv_drive_out_type drive_out,
  output logic [15:0] status_word
);
  import dpv_pkg::*;

  // refuse an address port too narrow for the register map
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_addr_check
    $error("ADDR_W must lie between 5 and 8");
  end

  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] tvel_reg, tvel_next;
  logic [15:0] sp_held_reg, sp_held_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] status_reg, status_next;
  logic [15:0] run_reg, run_next;
  logic [15:0] qs_reg, qs_next;
  logic [15:0] opt_reg, opt_next;
  logic [15:0] spout_reg, spout_next;
  logic strobe_reg, strobe_next;
  logic fr_pend_reg, fr_pend_next;
  logic run_pend_reg, run_pend_next;
  dpv_state_type state_reg, state_next;
  dpv_cmd_type cmd_reg, cmd_next;

  logic wr_ctrl, wr_tvel, wr_sp;
  logic [7:0] addr8;
  logic net_ctrl, fault, ready, running, stopped;
  dpv_cmd_type decoded;

  // address decode and drive status conditions
  always_comb begin
    addr8 = 8'(reg_addr);
    wr_ctrl = reg_wr && (addr8 == DPV_OFS_CONTROL);
    wr_tvel = reg_wr && (addr8 == DPV_OFS_TARGET_VEL);
    wr_sp = reg_wr && (addr8 == DPV_OFS_SETPOINT);
    net_ctrl = (drive_in.status_two & DPV_ST2_NET_CTRL) != 16'h0000;
    fault = (drive_in.status_fc & DPV_FC_FAULT) != 16'h0000;
    ready = (drive_in.status_fc & DPV_FC_READY) != 16'h0000;
    running = ((drive_in.status_fc & DPV_FC_RUN) != 16'h0000) &&
              ((drive_in.status_fc & DPV_FC_SPEED) != 16'h0000);
    stopped = ((drive_in.status_fc & DPV_FC_RUN) == 16'h0000) &&
              ((drive_in.status_fc & DPV_FC_SPEED) == 16'h0000);
  end

  // control word decode; halt-high words other than the rising edge match nothing
  always_comb begin
    decoded = CMD_NONE;
    if (reg_wdata[DPV_CW_HALT_RESET] && !ctrl_reg[DPV_CW_HALT_RESET]) begin
      decoded = CMD_FAULT_RESET;
    end else if (reg_wdata[DPV_CW_HALT_RESET]) begin
      decoded = CMD_NONE;
    end else if (!reg_wdata[DPV_CW_ENABLE_VOLT]) begin
      decoded = CMD_DISABLE_VOLTAGE;
    end else if (!reg_wdata[DPV_CW_QUICK_STOP]) begin
      decoded = CMD_QUICK_STOP;
    end else if (!reg_wdata[DPV_CW_SWITCH_ON]) begin
      decoded = CMD_SHUTDOWN;
    end else if (!reg_wdata[DPV_CW_ENABLE_OP]) begin
      decoded = (state_reg == ST_READY) ? CMD_SWITCH_ON : CMD_DISABLE_OP;
    end else begin
      decoded = (state_reg == ST_READY) ? CMD_SWITCH_ON_ENABLE : CMD_ENABLE_OP;
    end
  end

  // next values of software registers, recorded command and drive orders
  always_comb begin
    ctrl_next = ctrl_reg;
    tvel_next = tvel_reg;
    sp_held_next = sp_held_reg;
    run_next = run_reg;
    qs_next = qs_reg;
    opt_next = opt_reg;
    strobe_next = 1'b0;
    fr_pend_next = 1'b0;
    run_pend_next = run_pend_reg;
    cmd_next = cmd_reg;

    // software writes
    if (wr_tvel) begin
      tvel_next = reg_wdata;
    end
    if (wr_sp && ctrl_reg[DPV_CW_RFG_UNLOCK]) begin
      sp_held_next = reg_wdata;
    end
    if (wr_ctrl) begin
      ctrl_next = reg_wdata;
      if (reg_wdata[DPV_CW_RFG_ENABLE]) begin
        opt_next = opt_reg | DPV_OPT_NET_REF;
      end else begin
        opt_next = opt_reg & ~DPV_OPT_NET_REF;
      end
      if (decoded != CMD_NONE) begin
        cmd_next = decoded;
        run_pend_next = 1'b0;
      end
    end

    // command orders toward the drive, only under network control
    if (wr_ctrl && net_ctrl) begin
      unique case (decoded)
        CMD_SHUTDOWN, CMD_SWITCH_ON, CMD_DISABLE_VOLTAGE, CMD_DISABLE_OP: begin
          qs_next = qs_reg & ~DPV_QS_SELECT;
          run_next = (run_reg & ~DPV_RUN_FIELD) | DPV_RUN_STOP;
          strobe_next = 1'b1;
        end
        CMD_QUICK_STOP: begin
          qs_next = qs_reg | DPV_QS_SELECT;
          run_next = (run_reg & ~DPV_RUN_FIELD) | DPV_RUN_STOP;
          strobe_next = 1'b1;
        end
        CMD_ENABLE_OP: begin
          run_next = (run_reg & ~DPV_RUN_FIELD) |
                     (tvel_reg[15] ? DPV_RUN_REV : DPV_RUN_FWD);
          strobe_next = 1'b1;
        end
        CMD_SWITCH_ON_ENABLE: begin
          qs_next = qs_reg & ~DPV_QS_SELECT;
          run_next = (run_reg & ~DPV_RUN_FIELD) | DPV_RUN_STOP;
          run_pend_next = 1'b1;
          strobe_next = 1'b1;
        end
        CMD_FAULT_RESET: begin
          run_next = (run_reg & ~(DPV_RUN_FIELD | DPV_FAULT_RESET)) | DPV_RUN_STOP;
          fr_pend_next = 1'b1;
          strobe_next = 1'b1;
        end
        CMD_NONE: begin
        end
      endcase
    end else if (fr_pend_reg && net_ctrl) begin
      run_next = run_reg | DPV_FAULT_RESET;
      strobe_next = 1'b1;
    end else if (run_pend_reg && state_reg == ST_SWITCHED_ON && net_ctrl) begin
      run_next = (run_reg & ~DPV_RUN_FIELD) |
                 (tvel_reg[15] ? DPV_RUN_REV : DPV_RUN_FWD);
      run_pend_next = 1'b0;
      strobe_next = 1'b1;
    end
    // fault reset bit falls back once halt is released
    if (wr_ctrl && !reg_wdata[DPV_CW_HALT_RESET] && net_ctrl &&
        (run_reg & DPV_FAULT_RESET) != 16'h0000) begin
      run_next = run_next & ~DPV_FAULT_RESET;
      strobe_next = 1'b1;
    end

  end

  // profile state machine evaluated every cycle from drive status and last command
  always_comb begin
    state_next = state_reg;
    // a fault outranks every command, so it is tested first
    if (fault) begin
      state_next = running ? ST_FAULT_REACTION : (stopped ? ST_FAULT : state_reg);
    end else if (state_reg == ST_NOT_READY) begin
      if (init_ok && ready) begin
        state_next = ST_SWITCH_ON_DISABLED;
      end
    end else if (!ready) begin
      state_next = ST_NOT_READY;
    end else if (running) begin
      if (cmd_reg == CMD_QUICK_STOP) begin
        state_next = ST_QUICK_STOP;
      end else if (state_reg == ST_QUICK_STOP) begin
        state_next = (cmd_reg == CMD_ENABLE_OP) ? ST_OP_ENABLED : ST_QUICK_STOP;
      end else if (state_reg != ST_FAULT_REACTION && state_reg != ST_FAULT) begin
        state_next = ST_OP_ENABLED;
      end
    end else if (stopped) begin
      if (cmd_reg == CMD_SHUTDOWN &&
          (state_reg == ST_SWITCH_ON_DISABLED || state_reg == ST_SWITCHED_ON ||
           state_reg == ST_OP_ENABLED || state_reg == ST_READY)) begin
        state_next = ST_READY;
      end else if ((cmd_reg == CMD_SWITCH_ON || cmd_reg == CMD_DISABLE_OP ||
                    cmd_reg == CMD_SWITCH_ON_ENABLE || cmd_reg == CMD_ENABLE_OP) &&
                   (state_reg == ST_READY || state_reg == ST_OP_ENABLED ||
                    state_reg == ST_SWITCHED_ON)) begin
        state_next = ST_SWITCHED_ON;
      end else begin
        state_next = ST_SWITCH_ON_DISABLED;
      end
    end
  end

  // status word encode and gated set-point toward the drive
  always_comb begin
    status_next = 16'h0000;
    unique case (state_next)
      ST_NOT_READY: status_next[6:0] = 7'h00;
      ST_SWITCH_ON_DISABLED: status_next[6:0] = 7'h40;
      ST_READY: status_next[6:0] = 7'h21;
      ST_SWITCHED_ON: status_next[6:0] = 7'h33;
      ST_OP_ENABLED: status_next[6:0] = 7'h37;
      ST_QUICK_STOP: status_next[6:0] = 7'h17;
      ST_FAULT_REACTION: status_next[6:0] = 7'h1F;
      ST_FAULT: status_next[6:0] = 7'h08;
    endcase
    status_next[7] = (drive_in.status_fc & DPV_FC_WARNING) != 16'h0000;
    status_next[9] = (drive_in.status_two & DPV_ST2_REMOTE) != 16'h0000;
    status_next[10] = (drive_in.status_fc & DPV_FC_TARGET) != 16'h0000;
    if (state_next == ST_OP_ENABLED && ctrl_next[DPV_CW_RFG_USE_REF]) begin
      spout_next = sp_held_next;
    end else begin
      spout_next = 16'h0000;
    end
  end

  // register read mux, data stands in the cycle after the strobe
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_rd) begin
      unique case (addr8)
        DPV_OFS_CONTROL: rdata_next = ctrl_reg;
        DPV_OFS_TARGET_VEL: rdata_next = tvel_reg;
        DPV_OFS_SETPOINT: rdata_next = sp_held_reg;
        DPV_OFS_STATUS: rdata_next = status_reg;
        DPV_OFS_STATE: rdata_next = {4'h0, 4'(cmd_reg), 5'h00, 3'(state_reg)};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  // software, command and order registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= DPV_RESET_WORD;
      tvel_reg <= DPV_RESET_WORD;
      sp_held_reg <= DPV_RESET_WORD;
      run_reg <= DPV_RESET_WORD;
      qs_reg <= DPV_RESET_WORD;
      opt_reg <= DPV_RESET_WORD;
      strobe_reg <= 1'b0;
      fr_pend_reg <= 1'b0;
      run_pend_reg <= 1'b0;
      cmd_reg <= CMD_NONE;
    end else begin
      ctrl_reg <= ctrl_next;
      tvel_reg <= tvel_next;
      sp_held_reg <= sp_held_next;
      run_reg <= run_next;
      qs_reg <= qs_next;
      opt_reg <= opt_next;
      strobe_reg <= strobe_next;
      fr_pend_reg <= fr_pend_next;
      run_pend_reg <= run_pend_next;
      cmd_reg <= cmd_next;
    end
  end

  // profile state register; reset lands in not ready
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_NOT_READY;
    end else begin
      state_reg <= state_next;
    end
  end

  // status word and gated set-point; both follow the state register in step
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= DPV_RESET_WORD;
      spout_reg <= DPV_RESET_WORD;
    end else begin
      status_reg <= status_next;
      spout_reg <= spout_next;
    end
  end

  // read data, zero except in the cycle after a read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= DPV_RESET_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign status_word = status_reg;
  assign drive_out.run_ctrl = run_reg;
  assign drive_out.qs_ctrl = qs_reg;
  assign drive_out.option_status_word_two = opt_reg;
  assign drive_out.setpoint = spout_reg;
  assign drive_out.order_strobe = strobe_reg;

endmodule

// ---- dpv_velocity_sm_sva.sv ----
/* Assertions on the ports of the velocity interpreter.
   Assumes one clock, reset low-active, bound at the foot of this file. */
`timescale 1ns/1ps
module dpv_velocity_sm_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic init_ok,
  input wire dpv_pkg::dpv_drive_in_type drive_in,
  input wire dpv_pkg::dpv_drive_out_type drive_out,
  input wire logic [15:0] status_word
);
  import dpv_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic cw_wr;
  logic net;
  logic cw7_reg;
  logic neg_reg;
  // control word write and network control
  assign cw_wr = reg_wr && reg_addr == ADDR_W'(DPV_OFS_CONTROL);
  assign net = drive_in.status_two[1];
  // last halt bit written and sign of target velocity
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cw7_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else begin
      if (cw_wr) cw7_reg <= reg_wdata[7];
      if (reg_wr && reg_addr == ADDR_W'(DPV_OFS_TARGET_VEL)) neg_reg <= reg_wdata[15];
    end
  end
  // fault reset: stop with reset bit low, then reset bit high
  sequence s_fr_req;
    cw_wr && net && reg_wdata[7] && !cw7_reg;
  endsequence
  sequence s_fr_orders;
    ##1 (drive_out.run_ctrl[1:0] == 2'h0 && !drive_out.run_ctrl[3]) ##1 drive_out.run_ctrl[3];
  endsequence
  a_fault_reset_steps: assert property (s_fr_req |-> s_fr_orders)
    else $error("fault reset orders out of step");
  a_network_reference_flag_copy: assert property (cw_wr |=> drive_out.option_status_word_two[1] == $past(reg_wdata[4]))
    else $error("reference flag differs from control bit");
  a_status_reserved: assert property (status_word[13:12] == 2'b00)
    else $error("reserved status bits set");
  a_target_mirror: assert property ($past(nrst) |-> status_word[10] == $past(drive_in.status_fc[4]))
    else $error("target reached bit wrong");
  a_stop_orders: assert property (cw_wr && net && !reg_wdata[7] && (!reg_wdata[1] || reg_wdata[2:0] == 3'b110
    || reg_wdata[3:0] == 4'b0111) |=> drive_out.run_ctrl[1:0] == 2'h0 && !drive_out.qs_ctrl[2])
    else $error("stop command orders wrong");
  a_quick_stop: assert property (cw_wr && net && !reg_wdata[7] && reg_wdata[2:1] == 2'b01
    |=> drive_out.qs_ctrl[2] && drive_out.run_ctrl[1:0] == 2'h0 && drive_out.order_strobe)
    else $error("quick stop orders wrong");
  a_run_direction: assert property (cw_wr && net && !reg_wdata[7] && reg_wdata[3:0] == 4'hF && status_word[1]
    |=> drive_out.run_ctrl[1:0] == (neg_reg ? 2'h2 : 2'h1))
    else $error("run direction wrong");
  a_silent_offline: assert property (cw_wr && !net
    |=> !drive_out.order_strobe && $stable(drive_out.run_ctrl) && $stable(drive_out.qs_ctrl))
    else $error("order issued without network control");
  a_fault_stopped: assert property ($past(nrst) && $past(drive_in.status_fc[7])
    && $past(drive_in.status_fc[2:0]) == 3'h0 |-> status_word[3:0] == 4'h8)
    else $error("fault state bits wrong");
  a_setpoint_gate: assert property (!status_word[2] && !$past(status_word[2])
    |-> drive_out.setpoint == 16'h0000)
    else $error("set-point passed outside operation");
endmodule

bind dpv_velocity_sm dpv_velocity_sm_sva #(.ADDR_W(ADDR_W)) u_sva (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .init_ok(init_ok),
  .drive_in(drive_in), .drive_out(drive_out), .status_word(status_word));

// ---- dpv_drive_model.sv ----
/* Behavioural drive: run orders make it run, stop lets it coast down.
   Assumes the interpreter's clock and reset. */
`timescale 1ns/1ps
module dpv_drive_model (
  input wire logic clk,
  input wire logic nrst,
  input wire dpv_pkg::dpv_drive_out_type drive_out,
  input wire logic fault_inj,
  input wire logic ready,
  input wire logic net_ctrl,
  output dpv_pkg::dpv_drive_in_type drive_in
);
  import dpv_pkg::*;
  logic [2:0] speed_reg;
  logic fault_reg;
  // four cycles of run-down, so a quick stop takes time; fault held until reset order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      speed_reg <= 3'h0;
      fault_reg <= 1'b0;
    end else begin
      if (drive_out.run_ctrl[1:0] != 2'h0) speed_reg <= 3'h4;
      else if (speed_reg != 3'h0) speed_reg <= speed_reg - 3'h1;
      if (fault_inj) fault_reg <= 1'b1;
      else if (drive_out.run_ctrl[3]) fault_reg <= 1'b0;
    end
  end
  // status image: fault, ready, at speed, speed and running
  assign drive_in.status_fc = {8'h00, fault_reg, 1'b0, ready, speed_reg == 3'h4, 2'b00,
    speed_reg != 3'h0, speed_reg != 3'h0};
  assign drive_in.status_two = net_ctrl ? DPV_ST2_NET_CTRL : 16'h0000;
endmodule

// ---- dpv_velocity_sm_bench.sv ----
/* Self-checking bench for the velocity interpreter with a behavioural drive.
   Assumes read data one cycle after the read strobe. */
`timescale 1ns/1ps
module dpv_velocity_sm_bench;
  import dpv_pkg::*;
  typedef struct {
    logic [15:0] cw;
    logic [15:0] st;
    logic [15:0] run;
    logic [15:0] qs;
  } dpv_row_type;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic init_ok = 1'b0;
  logic fault_inj = 1'b0;
  logic ready = 1'b1;
  logic net_ctrl = 1'b1;
  logic [15:0] reg_rdata;
  logic [15:0] status_word;
  logic [15:0] v;
  dpv_drive_in_type drive_in;
  dpv_drive_out_type drive_out;
  int error_cnt = 0;
  int checked = 0;
  // control word, status, run image, quick-stop image
  dpv_row_type rows [8] = '{
    '{16'h0006, 16'h0221, 16'h0000, 16'h0000},
    '{16'h0007, 16'h0233, 16'h0000, 16'h0000},
    '{16'h007F, 16'h0637, 16'h0002, 16'h0000},
    '{16'h007B, 16'h0240, 16'h0000, 16'h0004},
    '{16'h0006, 16'h0221, 16'h0000, 16'h0000},
    '{16'h000F, 16'h0637, 16'h0002, 16'h0000},
    '{16'h0007, 16'h0233, 16'h0000, 16'h0000},
    '{16'h0000, 16'h0240, 16'h0000, 16'h0000}};
  dpv_velocity_sm dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .init_ok(init_ok), .drive_in(drive_in), .drive_out(drive_out),
    .status_word(status_word));
  dpv_drive_model drive (.clk(clk), .nrst(nrst), .drive_out(drive_out), .fault_inj(fault_inj), .ready(ready),
    .net_ctrl(net_ctrl), .drive_in(drive_in));
  always #5 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic settle();
    repeat (12) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence: reset, state walk, then awkward cases
  initial begin
    repeat (10) @(posedge clk);
    chk(status_word, 16'h0000);
    nrst <= 1'b1;
    settle();
    chk(status_word, 16'h0200);
    @(posedge clk) init_ok <= 1'b1;
    wr(DPV_OFS_TARGET_VEL, 16'hFFF6);
    settle();
    chk(status_word, 16'h0240);
    foreach (rows[i]) begin
      wr(DPV_OFS_CONTROL, rows[i].cw);
      settle();
      rd(DPV_OFS_STATUS, v);
      chk(v, rows[i].st);
      chk(drive_out.run_ctrl, rows[i].run);
      chk(drive_out.qs_ctrl, rows[i].qs);
    end
    // network control withdrawn: state follows, no orders
    @(posedge clk) net_ctrl <= 1'b0;
    wr(DPV_OFS_CONTROL, 16'h0002);
    settle();
    chk(drive_out.qs_ctrl, 16'h0000);
    chk(status_word, 16'h0040);
    // fault while stopped, then halt bit rise clears it
    @(posedge clk) net_ctrl <= 1'b1;
    fault_inj <= 1'b1;
    settle();
    chk(status_word, 16'h0208);
    @(posedge clk) fault_inj <= 1'b0;
    wr(DPV_OFS_CONTROL, 16'h0080);
    settle();
    chk(drive_out.run_ctrl, 16'h0008);
    chk(status_word, 16'h0240);
    // set-point gating by unlock and use-reference bits
    wr(DPV_OFS_CONTROL, 16'h0026);
    wr(DPV_OFS_SETPOINT, 16'h1234);
    wr(DPV_OFS_CONTROL, 16'h006F);
    settle();
    chk(drive_out.setpoint, 16'h1234);
    wr(DPV_OFS_CONTROL, 16'h004F);
    wr(DPV_OFS_SETPOINT, 16'h5555);
    settle();
    chk(drive_out.setpoint, 16'h1234);
    wr(DPV_OFS_TARGET_VEL, 16'h0010);
    wr(DPV_OFS_CONTROL, 16'h000F);
    settle();
    chk(drive_out.setpoint, 16'h0000);
    chk(drive_out.run_ctrl, 16'h0001);
    rd(DPV_OFS_STATE, v);
    chk(v, 16'h0704);
    rd(8'h1C, v);
    chk(v, 16'h0000);
    // drive loses readiness after stopping
    wr(DPV_OFS_CONTROL, 16'h0000);
    settle();
    chk(drive_out.option_status_word_two, 16'h0000);
    @(posedge clk) ready <= 1'b0;
    settle();
    chk(status_word, 16'h0200);
    tally_and_finish();
  end
  // hang guard
  initial begin
    #300us;
    error_cnt++;
    tally_and_finish();
  end
endmodule
